// *** macx_config.sv ***
// Retry, backoff seed and auto-ack configuration registers with ack decisions
// Behaviour
// - Upper nibble sets frame retransmission limit
// - Bits 3:1 set backoff retry limit
// - Value 7 skips CSMA; 6 reserved
// - Slot bit clear: ack sent unslotted
// - Slotted: ack waits for trigger rise
// - Seed is eleven bits, two registers
// - Backoff random generator seeded from seed
// - Bits 7:6 select max frame version
// - Frames above max version not acked
// - Ack frame version always zero
// - Pending bit copied for data requests
// - Pending bit also for secured v2/3 commands
// - Suppress bit blocks new acks; an ack already held for the slot trigger is still sent
// - Coordinator accepts source-only matching PAN
// - Both exponents zero give zero backoff
// - Exponent fields max 7:4, min 3:0
// - Live retry counts are readable
`timescale 1ns/1ns
`default_nettype none
module macx_config import macx_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_sleep_tx_trigger_pin,
  input wire macx_rxhdr_t i_rxhdr,
  input wire logic [3:0] i_retransmit_count_now,
  input wire logic [2:0] i_backoff_retry_count_now,
  input wire logic i_seed_load,
  input wire logic i_backoff_step,
  output macx_cfg_t o_cfg,
  output logic o_csma_skip,
  output logic o_frame_accept,
  output logic o_ack_send,
  output logic o_ack_pending,
  output logic [1:0] o_ack_version,
  output logic [2:0] o_transaction_status,
  output logic [10:0] o_backoff_rand,
  output logic o_backoff_zero
);
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] retry_limits_reg, retry_limits_next;
  logic [7:0] seed_low_reg, seed_low_next;
  logic [7:0] ack_filter_reg, ack_filter_next;
  logic [7:0] backoff_exp_reg, backoff_exp_next;
  logic [7:0] rdata_reg, rdata_next;
  always_comb begin
    retry_limits_next = retry_limits_reg;
    seed_low_next = seed_low_reg;
    ack_filter_next = ack_filter_reg;
    backoff_exp_next = backoff_exp_reg;
    if (i_wr) begin
      if (i_addr == ADDR_RETRY_LIMITS) begin
        retry_limits_next = i_wdata;
      end else if (i_addr == ADDR_SEED_LOW) begin
        seed_low_next = i_wdata;
      end else if (i_addr == ADDR_ACK_FILTER) begin
        ack_filter_next = i_wdata;
      end else if (i_addr == ADDR_BACKOFF_EXP) begin
        backoff_exp_next = i_wdata;
      end
    end
  end
  // Reads are side-effect free; unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd) begin
      if (i_addr == ADDR_RETRY_LIMITS) begin
        rdata_next = retry_limits_reg;
      end else if (i_addr == ADDR_SEED_LOW) begin
        rdata_next = seed_low_reg;
      end else if (i_addr == ADDR_ACK_FILTER) begin
        rdata_next = ack_filter_reg;
      end else if (i_addr == ADDR_BACKOFF_EXP) begin
        rdata_next = backoff_exp_reg;
      end else if (i_addr == ADDR_RETRY_COUNTS) begin
        rdata_next = {i_retransmit_count_now, i_backoff_retry_count_now, 1'b0};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      retry_limits_reg <= RST_RETRY_LIMITS;
      seed_low_reg <= RST_SEED_LOW;
      ack_filter_reg <= RST_ACK_FILTER;
      backoff_exp_reg <= RST_BACKOFF_EXP;
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      retry_limits_reg <= retry_limits_next;
      seed_low_reg <= seed_low_next;
      ack_filter_reg <= ack_filter_next;
      backoff_exp_reg <= backoff_exp_next;
      rdata_reg <= rdata_next;
    end
  end
  assign o_rdata = rdata_reg;
  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  always_comb begin
    o_cfg.retx_limit = retry_limits_reg[RETX_LSB +: 4];
    o_cfg.backoff_retry_limit = retry_limits_reg[CSMA_LSB +: 3];
    o_cfg.slotted = retry_limits_reg[SLOT_BIT];
    o_cfg.max_frame_version_sel = ack_filter_reg[FVN_LSB +: 2];
    o_cfg.ack_pending_bit = ack_filter_reg[PEND_BIT];
    o_cfg.ack_suppress = ack_filter_reg[DIS_BIT];
    o_cfg.pan_coordinator_flag = ack_filter_reg[COORD_BIT];
    o_cfg.backoff_seed = {ack_filter_reg[2:0], seed_low_reg};
    o_cfg.backoff_exp_max = backoff_exp_reg[BEMAX_LSB +: 4];
    o_cfg.backoff_exp_min = backoff_exp_reg[3:0];
  end
  // Reserved code 6 is not trapped; software must avoid it
  assign o_csma_skip = (o_cfg.backoff_retry_limit == CSMA_IMMEDIATE);
  // Zero exponents force zero backoff regardless of the generator
  assign o_backoff_zero = (backoff_exp_reg == 8'h00);
  // ------------------------------------------------------------
  // Backoff random generator
  // ------------------------------------------------------------
  macx_lfsr #(.W(11)) u_lfsr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_load(i_seed_load),
    .i_seed(o_cfg.backoff_seed),
    .i_step(i_backoff_step),
    .o_rand(o_backoff_rand)
  );
  // ------------------------------------------------------------
  // Frame filter and ack decision
  // ------------------------------------------------------------
  function automatic logic version_ok(input logic [1:0] sel, input logic [1:0] ver);
    version_ok = (sel == 2'h3) || (ver <= sel);
  endfunction
  logic accept_c;
  logic pend_c;
  always_comb begin
    accept_c = i_rxhdr.valid && version_ok(o_cfg.max_frame_version_sel, i_rxhdr.version);
    if (i_rxhdr.src_only && !(o_cfg.pan_coordinator_flag && i_rxhdr.src_pan_match)) begin
      accept_c = 1'b0;
    end
    pend_c = 1'b0;
    if (i_rxhdr.ftype == FTYPE_CMD && i_rxhdr.cmd_id == CMD_DATA_REQ) begin
      pend_c = o_cfg.ack_pending_bit;
    end
    if (i_rxhdr.ftype == FTYPE_CMD && i_rxhdr.version[1] && i_rxhdr.sec_en &&
        o_cfg.max_frame_version_sel[1]) begin
      pend_c = o_cfg.ack_pending_bit;
    end
  end
  assign o_frame_accept = accept_c;
  // ------------------------------------------------------------
  // Slotted ack hold
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MACX_ACK_IDLE = 2'b00,
    MACX_ACK_WAIT = 2'b01
  } macx_ack_st_t;
  macx_ack_st_t st_reg, st_next;
  logic pend_reg, pend_next;
  logic send_reg, send_next;
  logic [2:0] trac_reg, trac_next;
  logic trig_rise;
  macx_slot_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pin(i_sleep_tx_trigger_pin),
    .o_rise(trig_rise)
  );
  logic want_ack;
  assign want_ack = accept_c && i_rxhdr.ack_req && !o_cfg.ack_suppress;
  always_comb begin
    st_next = st_reg;
    pend_next = pend_reg;
    send_next = 1'b0;
    trac_next = trac_reg;
    case (st_reg)
      MACX_ACK_IDLE: begin
        if (want_ack) begin
          pend_next = pend_c;
          if (o_cfg.slotted) begin
            st_next = MACX_ACK_WAIT;
            trac_next = MACX_TS_OK_WAIT_ACK;
          end else begin
            send_next = 1'b1;
            trac_next = MACX_TS_OK;
          end
        end
      end
      MACX_ACK_WAIT: begin
        // Edge timing against slot boundaries is the host's job
        if (trig_rise) begin
          send_next = 1'b1;
          st_next = MACX_ACK_IDLE;
          trac_next = MACX_TS_OK;
        end
      end
      default: st_next = MACX_ACK_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= MACX_ACK_IDLE;
      pend_reg <= 1'b0;
      send_reg <= 1'b0;
      trac_reg <= MACX_TS_IDLE;
    end else if (i_ce) begin
      st_reg <= st_next;
      pend_reg <= pend_next;
      send_reg <= send_next;
      trac_reg <= trac_next;
    end
  end
  assign o_ack_send = send_reg;
  assign o_ack_pending = pend_reg;
  assign o_ack_version = 2'h0;
  assign o_transaction_status = trac_reg;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_unslot_ack: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && want_ack && !o_cfg.slotted && st_reg == MACX_ACK_IDLE) |=> o_ack_send)
    else $error("unslotted ack not sent");
  a_slot_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_reg == MACX_ACK_WAIT && !trig_rise) |=> !o_ack_send)
    else $error("slotted ack sent without trigger");
  a_slot_status: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_reg == MACX_ACK_WAIT) |-> o_transaction_status == MACX_TS_OK_WAIT_ACK)
    else $error("wait status missing");
  a_suppress_ack: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && st_reg == MACX_ACK_IDLE && o_cfg.ack_suppress) |=> !o_ack_send)
    else $error("ack sent while suppressed");
  a_version_rej: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_cfg.max_frame_version_sel != 2'h3 && i_rxhdr.version > o_cfg.max_frame_version_sel)
    |-> !o_frame_accept)
    else $error("high version accepted");
  a_ack_ver: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_ack_send |-> o_ack_version == 2'h0)
    else $error("ack version not zero");
  a_csma_skip: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_csma_skip == (retry_limits_reg[3:1] == 3'h7))
    else $error("csma skip decode wrong");
  a_write_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == ADDR_SEED_LOW) ##1 (i_ce && i_rd && i_addr == ADDR_SEED_LOW && !i_wr)
    |=> o_rdata == $past(i_wdata, 2))
    else $error("readback mismatch");
  a_seed_form: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_cfg.backoff_seed[10:8] == ack_filter_reg[2:0])
    else $error("seed high bits wrong");
  a_zero_be: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_cfg.backoff_exp_max == 4'h0 && o_cfg.backoff_exp_min == 4'h0) |-> o_backoff_zero)
    else $error("zero backoff not flagged");
  a_slot_release: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && st_reg == MACX_ACK_WAIT && trig_rise) |=> o_ack_send)
    else $error("slotted ack not released");
  a_unslot_status: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && want_ack && !o_cfg.slotted && st_reg == MACX_ACK_IDLE)
    |=> o_transaction_status == MACX_TS_OK)
    else $error("unslotted status not ok");
  a_pend_copy: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && st_reg == MACX_ACK_IDLE && want_ack && i_rxhdr.ftype == FTYPE_CMD &&
    i_rxhdr.cmd_id == CMD_DATA_REQ) |=> o_ack_pending == $past(o_cfg.ack_pending_bit))
    else $error("pending bit not copied");
  a_sec_pend: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && st_reg == MACX_ACK_IDLE && want_ack && i_rxhdr.ftype == FTYPE_CMD &&
    i_rxhdr.version[1] && i_rxhdr.sec_en && o_cfg.max_frame_version_sel[1])
    |=> o_ack_pending == $past(o_cfg.ack_pending_bit))
    else $error("pending bit not copied for secured command");
  a_src_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_rxhdr.src_only && !(o_cfg.pan_coordinator_flag && i_rxhdr.src_pan_match))
    |-> !o_frame_accept)
    else $error("source-only frame accepted");
  a_read_pure: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_rd && !i_wr) |=> $stable(retry_limits_reg) && $stable(seed_low_reg) &&
    $stable(ack_filter_reg) && $stable(backoff_exp_reg))
    else $error("read changed a register");
  a_counts_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_rd && i_addr == ADDR_RETRY_COUNTS) |=> o_rdata ==
    {$past(i_retransmit_count_now), $past(i_backoff_retry_count_now), 1'b0})
    else $error("live counts not returned");
  a_rand_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_seed_load) |=> (o_backoff_rand == $past(o_cfg.backoff_seed)) ||
    ($past(o_cfg.backoff_seed) == 11'h000))
    else $error("generator not loaded from seed");
  // ------------------------------------------------------------
  // Coverage of the main scenarios
  // ------------------------------------------------------------
  c_unslot: cover property (@(posedge i_mclk) o_ack_send && !o_cfg.slotted);
  c_slot: cover property (@(posedge i_mclk) st_reg == MACX_ACK_WAIT ##[1:50] o_ack_send);
  c_pend: cover property (@(posedge i_mclk) o_ack_send && o_ack_pending);
  c_skip: cover property (@(posedge i_mclk) o_csma_skip);
  c_suppressed: cover property (@(posedge i_mclk) accept_c && i_rxhdr.ack_req && o_cfg.ack_suppress);
endmodule
`default_nettype wire

// *** macx_pkg.sv ***
// Package for the MAC accelerator retry and ack configuration block
package macx_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_RETRY_LIMITS = 6'h2c;
  localparam logic [5:0] ADDR_SEED_LOW = 6'h2d;
  localparam logic [5:0] ADDR_ACK_FILTER = 6'h2e;
  localparam logic [5:0] ADDR_BACKOFF_EXP = 6'h2f;
  localparam logic [5:0] ADDR_RETRY_COUNTS = 6'h19;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RETX_LSB = 4;
  localparam int CSMA_LSB = 1;
  localparam int SLOT_BIT = 0;
  localparam int FVN_LSB = 6;
  localparam int PEND_BIT = 5;
  localparam int DIS_BIT = 4;
  localparam int COORD_BIT = 3;
  localparam int BEMAX_LSB = 4;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_RETRY_LIMITS = 8'h38;
  localparam logic [7:0] RST_SEED_LOW = 8'hea;
  localparam logic [7:0] RST_ACK_FILTER = 8'h42;
  localparam logic [7:0] RST_BACKOFF_EXP = 8'h53;
  // ------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------
  localparam logic [2:0] CSMA_RESERVED = 3'h6;
  localparam logic [2:0] CSMA_IMMEDIATE = 3'h7;
  localparam logic [2:0] CSMA_MAX_RETRY = 3'h5;
  localparam logic [3:0] BE_LIMIT = 4'h8;
  localparam logic [1:0] FTYPE_CMD = 2'h3;
  localparam logic [7:0] CMD_DATA_REQ = 8'h04;
  typedef enum logic [2:0] {
    MACX_TS_OK = 3'h0,
    MACX_TS_OK_WAIT_ACK = 3'h2,
    MACX_TS_IDLE = 3'h7
  } macx_trac_t;
  // Decoded configuration carried to the ack and backoff logic
  typedef struct packed {
    logic [3:0] retx_limit;
    logic [2:0] backoff_retry_limit;
    logic slotted;
    logic [1:0] max_frame_version_sel;
    logic ack_pending_bit;
    logic ack_suppress;
    logic pan_coordinator_flag;
    logic [10:0] backoff_seed;
    logic [3:0] backoff_exp_max;
    logic [3:0] backoff_exp_min;
  } macx_cfg_t;
  // Received frame header summary
  typedef struct packed {
    logic valid;
    logic ack_req;
    logic [1:0] ftype;
    logic [1:0] version;
    logic sec_en;
    logic [7:0] cmd_id;
    logic src_only;
    logic src_pan_match;
  } macx_rxhdr_t;
endpackage

// *** macx_lfsr.sv ***
// Backoff pseudo-random generator seeded from the configured seed
`timescale 1ns/1ns
`default_nettype none
module macx_lfsr import macx_pkg::*; #(
  parameter int W = 11
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [W-1:0] i_seed,
  input wire logic i_step,
  output logic [W-1:0] o_rand
);
  // Taps are fixed for eleven bits, so any other width is refused
  if (W != 11) begin : g_bad_width
    $error("macx_lfsr supports W=11 only");
  end
  logic [W-1:0] lfsr_reg, lfsr_next;
  always_comb begin
    lfsr_next = lfsr_reg;
    if (i_load) begin
      // Zero seed would lock the register, so bit 0 is forced
      lfsr_next = i_seed | {{(W-1){1'b0}}, (i_seed == '0)};
    end else if (i_step) begin
      lfsr_next = {lfsr_reg[W-2:0], lfsr_reg[10] ^ lfsr_reg[8]};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lfsr_reg <= {RST_ACK_FILTER[2:0], RST_SEED_LOW};
    end else if (i_ce) begin
      lfsr_reg <= lfsr_next;
    end
  end
  assign o_rand = lfsr_reg;
endmodule
`default_nettype wire

// *** macx_slot_sync.sv ***
// Three-stage pin synchroniser with rising edge detect
`timescale 1ns/1ns
`default_nettype none
module macx_slot_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_rise
);
  logic [2:0] sync_reg, sync_next;
  logic lvl_reg, lvl_next;
  always_comb begin
    sync_next = {sync_reg[1:0], i_pin};
    lvl_next = lvl_reg;
    // Level changes only when stages two and three agree
    if (sync_reg[2] == sync_reg[1]) begin
      lvl_next = sync_reg[2];
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync_reg <= 3'h0;
      lvl_reg <= 1'b0;
    end else if (i_ce) begin
      sync_reg <= sync_next;
      lvl_reg <= lvl_next;
    end
  end
  assign o_rise = i_ce & lvl_next & ~lvl_reg;
endmodule
`default_nettype wire

// *** macx_host_model.sv ***
// Host microcontroller model: register bus cycles and the trigger pin
`timescale 1ns/1ns
`default_nettype none
module macx_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_trig
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
    o_trig = 1'b0;
  end
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Request held across one sampling edge, then released
  task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_mclk);
    o_wr = 1'b0;
    // Released data shows the inverse so no stale value looks valid
    o_wdata = ~d;
  endtask
  // Read raised on the edge that drops the write, so the read lands next cycle
  task automatic bus_write_read(input logic [5:0] a, input logic [7:0] v,
                                output logic [7:0] d);
    @(negedge i_mclk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_wdata = ~v;
    o_rd = 1'b1;
    @(negedge i_mclk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_mclk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  // ------------------------------------------------------------
  // Slot trigger
  // ------------------------------------------------------------
  // Edge placed on a slot boundary; held long enough for the synchroniser
  task automatic slot_trigger(input int wait_cycles);
    repeat (wait_cycles) @(negedge i_mclk);
    o_trig = 1'b1;
    repeat (8) @(negedge i_mclk);
    o_trig = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** mac_accel_retry_ack_config_tb_top.sv ***
// Self-checking testbench for the retry and ack configuration registers
`timescale 1ns/1ns
`default_nettype none
module mac_accel_retry_ack_config_tb_top import macx_pkg::*; ;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wr, i_rd, i_trig, i_seed_load = 1'b0, i_backoff_step = 1'b0;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [3:0] i_rtx = 4'h0;
  logic [2:0] i_csr = 3'h0;
  macx_rxhdr_t i_rxhdr = '0;
  macx_cfg_t o_cfg;
  logic o_skip, o_acc, o_ack, o_pend, o_bzero;
  logic [1:0] o_aver;
  logic [2:0] o_stat;
  logic [10:0] o_rand;
  logic [7:0] sh [4];
  int failures = 0;
  int comparisons = 0;
  int acks = 0;
  int a0;
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) acks <= acks + int'(o_ack === 1'b1);
  macx_host_model u_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_trig(i_trig));
  macx_config u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sleep_tx_trigger_pin(i_trig),
    .i_rxhdr(i_rxhdr), .i_retransmit_count_now(i_rtx), .i_backoff_retry_count_now(i_csr),
    .i_seed_load(i_seed_load), .i_backoff_step(i_backoff_step), .o_cfg(o_cfg),
    .o_csma_skip(o_skip), .o_frame_accept(o_acc), .o_ack_send(o_ack), .o_ack_pending(o_pend),
    .o_ack_version(o_aver), .o_transaction_status(o_stat), .o_backoff_rand(o_rand),
    .o_backoff_zero(o_bzero));
  // ------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------
  function automatic macx_cfg_t exp_cfg();
    macx_cfg_t c;
    c = {sh[0][7:1], sh[0][0], sh[2][7:3], sh[2][2:0], sh[1], sh[3]};
    return c;
  endfunction
  function automatic logic exp_acc(logic [7:0] af, macx_rxhdr_t h);
    logic ok;
    ok = (af[7:6] == 2'h3) || (h.version <= af[7:6]);
    return h.valid && ok && (!h.src_only || (af[3] && h.src_pan_match));
  endfunction
  function automatic logic exp_pend(logic [7:0] af, macx_rxhdr_t h);
    logic sec;
    sec = af[7:6] >= 2'h2 && h.version >= 2'h2 && h.sec_en;
    return af[5] && h.ftype == FTYPE_CMD && (h.cmd_id == CMD_DATA_REQ || sec);
  endfunction
  task automatic wr_sh(input int k, input logic [7:0] v);
    sh[k] = v;
    u_host.bus_write(ADDR_RETRY_LIMITS + 6'(k), v);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(96282));
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    sh = '{RST_RETRY_LIMITS, RST_SEED_LOW, RST_ACK_FILTER, RST_BACKOFF_EXP};
    for (int k = 0; k < 4; k++) begin
      u_host.bus_read(ADDR_RETRY_LIMITS + 6'(k), d);
      `CHK("reset value", sh[k], d)
    end
    `CHK("idle status", 3'h7, o_stat)
    // Corners first, then random legal values
    for (int i = 0; i < 44; i++) begin
      d = (i < 4) ? (i == 3 ? 8'h00 : (i == 1 ? 8'h00 : (i == 2 ? 8'hff : 8'h7e))) : 8'($urandom);
      if (i % 4 == 0 && d[3:1] == CSMA_RESERVED) d[3:1] = CSMA_IMMEDIATE;
      if (i % 4 == 3 && i >= 4) d[7:4] = d[7:4] % 9;
      if (i % 4 == 3 && i >= 4) d[3:0] = d[3:0] % (d[7:4] + 1);
      wr_sh(i % 4, d);
      u_host.bus_read(ADDR_RETRY_LIMITS + 6'(i % 4), d);
      `CHK("readback", sh[i % 4], d)
      `CHK("decoded config", exp_cfg(), o_cfg)
      `CHK("csma skip", sh[0][3:1] == CSMA_IMMEDIATE, o_skip)
      `CHK("zero backoff", sh[3] == 8'h00, o_bzero)
    end
    i_rtx = 4'($urandom);
    i_csr = 3'($urandom % 6);
    u_host.bus_write(ADDR_RETRY_COUNTS, 8'h00);
    u_host.bus_read(ADDR_RETRY_COUNTS, d);
    `CHK("live counts", {i_rtx, i_csr, 1'b0}, d)
    u_host.bus_write(6'h30, 8'h5a);
    u_host.bus_read(6'h30, d);
    `CHK("unmapped read", 8'h00, d)
    i_ce = 1'b0;
    u_host.bus_write(ADDR_SEED_LOW, ~sh[1]);
    i_ce = 1'b1;
    u_host.bus_read(ADDR_SEED_LOW, d);
    `CHK("frozen write", sh[1], d)
    // Write and read on adjacent edges must see the new value
    sh[1] = 8'($urandom);
    u_host.bus_write_read(ADDR_SEED_LOW, sh[1], d);
    `CHK("write then read", sh[1], d)
    // Seed load and step of the backoff generator
    wr_sh(1, 8'($urandom) | 8'h01);
    @(negedge i_mclk);
    i_seed_load = 1'b1;
    @(negedge i_mclk);
    i_seed_load = 1'b0;
    `CHK("loaded seed", {sh[2][2:0], sh[1]}, o_rand)
    i_backoff_step = 1'b1;
    @(negedge i_mclk);
    i_backoff_step = 1'b0;
    `CHK("generator moved", 1'b1, o_rand !== {sh[2][2:0], sh[1]})
    // Unslotted frames against random filter settings
    wr_sh(0, 8'h38);
    for (int i = 0; i < 80; i++) begin
      wr_sh(2, 8'($urandom));
      @(negedge i_mclk);
      i_rxhdr = macx_rxhdr_t'($urandom);
      i_rxhdr.valid = 1'b1;
      // Data requests and secured newer commands are too rare at random
      if (i % 4 == 1 || i % 4 == 2) begin
        i_rxhdr.ftype = FTYPE_CMD;
        i_rxhdr.ack_req = 1'b1;
        i_rxhdr.src_only = 1'b0;
      end
      if (i % 4 == 1) begin
        i_rxhdr.cmd_id = CMD_DATA_REQ;
      end else if (i % 4 == 2) begin
        i_rxhdr.version = 2'h2;
        i_rxhdr.sec_en = 1'b1;
      end
      #1;
      `CHK("frame accept", exp_acc(sh[2], i_rxhdr), o_acc)
      @(negedge i_mclk);
      `CHK("ack sent", exp_acc(sh[2], i_rxhdr) && i_rxhdr.ack_req && !sh[2][4], o_ack)
      if (o_ack === 1'b1) begin
        `CHK("pending bit", exp_pend(sh[2], i_rxhdr), o_pend)
        `CHK("ack version", 2'h0, o_aver)
        `CHK("ok status", 3'(MACX_TS_OK), o_stat)
      end
      i_rxhdr = '0;
    end
    // Slotted ack waits for the trigger edge
    wr_sh(0, 8'h39);
    wr_sh(2, 8'h42);
    @(negedge i_mclk);
    i_rxhdr = '{valid: 1'b1, ack_req: 1'b1, default: '0};
    @(negedge i_mclk);
    i_rxhdr = '0;
    a0 = acks;
    repeat (4) @(negedge i_mclk);
    `CHK("held ack", a0, acks)
    `CHK("awaiting status", 3'(MACX_TS_OK_WAIT_ACK), o_stat)
    u_host.slot_trigger(2);
    `CHK("released ack", a0 + 1, acks)
    `CHK("ok status", 3'(MACX_TS_OK), o_stat)
    // A reset in mid-run must restore registers, status and generator
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    `CHK("status after reset", 3'(MACX_TS_IDLE), o_stat)
    `CHK("seed after reset", {RST_ACK_FILTER[2:0], RST_SEED_LOW}, o_rand)
    u_host.bus_read(ADDR_ACK_FILTER, d);
    `CHK("filter after reset", RST_ACK_FILTER, d)
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
